// ---- hold_clear_policy.v ----
// output hold/clear policy with apb registers and per-output on counters
`timescale 1ns/1ps
`include "hold_clear_map.vh"

module hold_clear_policy #(
  parameter N = 8,
  parameter CW = 16,
  parameter [7:0] FW_REV = 8'h10 // arbitrary revision value
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire link_up,
  input wire cyclic_run,
  input wire [2:0] cpu_state,
  input wire internal_fault,
  input wire [N-1:0] cyclic_output_bits,
  input wire [N-1:0] raw_inputs,
  output wire [N-1:0] out_level,
  output wire out_data_valid,
  output wire out_data_held,
  output wire [N-1:0] cyclic_input_bits
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [31:0] ctrl_q;
  reg [N-1:0] out_q;
  reg [N-1:0] out_d;
  reg [N-1:0] in_q;
  reg valid_q;
  reg valid_d;
  reg held_q;
  reg held_d;
  wire [N*CW-1:0] cnt_bus;
  reg [31:0] rd_word;
  wire apb_wr;
  wire apb_setup_rd;
  wire link_ok;
  wire eff_hold;
  wire sio_mode;
  integer i;

  // zero-wait slave: every access completes in its first access cycle;
  // read data is fetched in the setup cycle so it can leave a flip-flop
  assign apb_wr = psel && penable && pwrite;
  assign apb_setup_rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // counter window decode, one word per channel;
  // shared by the write strobes and the read word
  function cnt_hit;
    input [11:0] a;
    input integer ch;
    begin
      cnt_hit = (a == (`REG_CNT_BASE + ch[9:0] * 12'h004));
    end
  endfunction

  // ---------------------------------------------------------------
  // policy decode
  // ---------------------------------------------------------------
  // priority, highest first: internal fault, then link loss or cpu
  // reset (hold or clear), then the cpu state itself. a fault wins over
  // hold because a failed module must not keep driving its loads.
  assign link_ok = link_up && cyclic_run;
  assign eff_hold = ctrl_q[`CTRL_HOLD_BIT] || (FW_REV == `FW_HOLD_ONLY);
  assign sio_mode = ctrl_q[`CTRL_SIO_BIT];

  // next outputs; registered so a change lands one cycle later
  always @* begin
    out_d = out_q;
    valid_d = 1'b0;
    held_d = 1'b0;
    if (internal_fault) begin
      out_d = {N{1'b0}};
    end else if (!link_ok || cpu_state == `CPU_RESET) begin
      // link loss and cpu reset share handling
      // hold keeps out_q as it stands; valid keeps its value in io-link
      if (eff_hold) begin
        held_d = 1'b1;
        valid_d = !sio_mode && valid_q;
      end else begin
        out_d = {N{1'b0}};
      end
    end else begin
      case (cpu_state)
        `CPU_RUN, `CPU_PAUSE: begin
          out_d = cyclic_output_bits;
          valid_d = 1'b1;
        end
        `CPU_STOP, `CPU_ERR: begin
          // in sio the master already chose on/off for us
          out_d = cyclic_output_bits;
          valid_d = sio_mode ? 1'b1 : eff_hold;
          if (!sio_mode && !eff_hold) begin
            out_d = {N{1'b0}};
          end
        end
        // undefined cpu codes fail safe: off and invalid
        default: begin
          out_d = {N{1'b0}};
          valid_d = 1'b0;
        end
      endcase
    end
  end

  // output and input registers
  // inputs toward the master are cleared here under the same fault
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= {N{1'b0}};
      in_q <= {N{1'b0}};
      valid_q <= 1'b0;
      held_q <= 1'b0;
    end else begin
      out_q <= out_d;
      valid_q <= valid_d;
      held_q <= held_d;
      in_q <= internal_fault ? {N{1'b0}} : raw_inputs;
    end
  end

  assign out_level = out_q;
  assign out_data_valid = valid_q;
  assign out_data_held = held_q;
  assign cyclic_input_bits = in_q;

  // ---------------------------------------------------------------
  // on counters
  // ---------------------------------------------------------------
  // one counter per output, fed from the registered level so a glitch
  // on the command between edges can never be counted
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_cnt
      on_counter #(.CW(CW)) u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .level(out_q[g]),
        .wr_en(apb_wr && cnt_hit(paddr, g)),
        .wr_data(pwdata[CW-1:0]),
        .count(cnt_bus[g*CW +: CW])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  // single setting written by the master covers every output
  // only the two defined bits are kept; the rest read back zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (apb_wr && paddr == `REG_CTRL) begin
      ctrl_q <= {30'h0, pwdata[`CTRL_SIO_BIT],
        pwdata[`CTRL_HOLD_BIT]};
    end
  end

  // read word for the addressed register; unmapped addresses read zero
  always @* begin
    rd_word = `APB_OKAY;
    case (paddr)
      `REG_CTRL: rd_word = ctrl_q;
      `REG_STATUS: begin
        rd_word[`ST_VALID_BIT] = valid_q;
        rd_word[`ST_HELD_BIT] = held_q;
        rd_word[`ST_FORCED_OFF_BIT] = internal_fault;
        rd_word[`ST_EFF_HOLD_BIT] = eff_hold;
      end
      `REG_OUT_CMD: rd_word[N-1:0] = out_q;
      `REG_IN_RAW: rd_word[N-1:0] = in_q;
      `REG_FW_REV: rd_word[7:0] = FW_REV;
      default: begin
        for (i = 0; i < N; i = i + 1) begin
          if (cnt_hit(paddr, i)) begin
            rd_word[CW-1:0] = cnt_bus[i*CW +: CW];
          end
        end
      end
    endcase
  end

  // captured in the setup cycle, shown through the access cycle, then
  // cleared. limitation: a counter that steps during the access cycle
  // reads back its value from the setup cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `APB_OKAY;
    end else if (apb_setup_rd) begin
      prdata <= rd_word;
    end else begin
      prdata <= `APB_OKAY;
    end
  end

endmodule // hold_clear_policy

// ---- hold_clear_map.vh ----
// register offsets, field positions, encodings and reset values for the policy
`ifndef HOLD_CLEAR_MAP_VH
`define HOLD_CLEAR_MAP_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_OUT_CMD 12'h008
`define REG_IN_RAW 12'h00C
`define REG_FW_REV 12'h010
`define REG_CNT_BASE 12'h040
`define REG_CNT_LAST 12'h05C

// ---------------------------------------------------------------
// ctrl fields
// ---------------------------------------------------------------
`define CTRL_HOLD_BIT 0
`define CTRL_SIO_BIT 1
`define CTRL_RESET 32'h0000_0000

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define ST_VALID_BIT 0
`define ST_HELD_BIT 1
`define ST_FORCED_OFF_BIT 2
`define ST_EFF_HOLD_BIT 3

// ---------------------------------------------------------------
// cpu operating states
// ---------------------------------------------------------------
`define CPU_RUN 3'h0
`define CPU_STOP 3'h1
`define CPU_PAUSE 3'h2
`define CPU_RESET 3'h3
`define CPU_ERR 3'h4

// ---------------------------------------------------------------
// misc values
// ---------------------------------------------------------------
`define FW_HOLD_ONLY 8'h3B // arbitrary value for the early hold-only revision
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define CNT_MAX 16'hFFFF
`define APB_OKAY 32'h0000_0000

`endif

// ---- on_counter.v ----
// one output channel's ON-transition total, writable by software
`timescale 1ns/1ps
`include "hold_clear_map.vh"

module on_counter #(
  parameter CW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire level,
  input wire wr_en,
  input wire [CW-1:0] wr_data,
  output wire [CW-1:0] count
);

  reg level_q;
  reg [CW-1:0] count_q;
  reg [CW-1:0] count_d;

  // rising edge of the driven level counts; software write wins
  always @* begin
    count_d = count_q;
    if (wr_en) begin
      count_d = wr_data;
    end else if (level && !level_q && count_q != `CNT_MAX) begin
      count_d = count_q + `CNT_ONE;
    end
  end

  // saturate at top of range rather than wrapping to zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      count_q <= `CNT_ZERO;
    end else begin
      level_q <= level;
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule // on_counter

// ---- policy_monitor.sv ----
// assertion checker on the hold/clear policy ports
`timescale 1ns/1ps
`include "hold_clear_map.vh"
module policy_monitor #(
  parameter N = 8
) (
  input wire pclk,
  input wire presetn,
  input wire link_up,
  input wire cyclic_run,
  input wire [2:0] cpu_state,
  input wire internal_fault,
  input wire [N-1:0] cyclic_output_bits,
  input wire [N-1:0] out_level,
  input wire out_data_valid,
  input wire out_data_held,
  input wire [N-1:0] cyclic_input_bits
);
  // healthy link, run state, outputs off and invalid
  wire ok = link_up && cyclic_run && !internal_fault;
  wire run = ok && cpu_state == `CPU_RUN;
  wire off = out_level == '0 && !out_data_valid;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // checks
  // ----
  AST_FAULT: assert property (internal_fault |=> out_level == '0
    && cyclic_input_bits == '0) else $error("fault left io on");
  AST_RUN: assert property (run |=> out_data_valid &&
    out_level == $past(cyclic_output_bits)) else $error("run");
  AST_RUN_FREE: assert property (run |=> !out_data_held)
    else $error("held in run");
  AST_PAUSE: assert property (ok && cpu_state == `CPU_PAUSE |=>
    out_level == $past(cyclic_output_bits)) else $error("pause");
  AST_LINK: assert property (!internal_fault && !(link_up && cyclic_run)
    |=> out_data_held || off) else $error("link loss");
  AST_CPU_RST: assert property (ok && cpu_state == `CPU_RESET
    |=> out_data_held || off) else $error("cpu reset");
  AST_KEEP: assert property (out_data_held && !internal_fault ##1
    out_data_held |-> $stable(out_level)) else $error("held moved");
  AST_BAD: assert property (ok && cpu_state > `CPU_ERR |=> off)
    else $error("bad state");
  cover property (out_data_held);
  cover property (internal_fault);
  cover property (ok && cpu_state == `CPU_PAUSE);
endmodule // policy_monitor
bind hold_clear_policy policy_monitor #(.N(N)) policy_monitor_i (.*);

// ---- net_master.sv ----
// network master model: link, cpu state, cyclic commands
`timescale 1ns/1ps
`include "hold_clear_map.vh"
module net_master (
  input wire pclk,
  output reg link_up = 1'b0,
  output reg cyclic_run = 1'b0,
  output reg [2:0] cpu_state = `CPU_STOP,
  output reg [7:0] cyclic_output_bits = 8'h00
);
  reg [7:0] cmd_q = 8'h00;
  reg stop_off = 1'b0; // master's own stop/error output choice
  // stop/error level is the master's call; lags cmd one cycle
  always @(posedge pclk) begin
    cyclic_output_bits <= (stop_off && (cpu_state == `CPU_STOP ||
      cpu_state == `CPU_ERR)) ? 8'h00 : cmd_q;
  end
  // link and cpu state move together, just after an edge
  task set(input l, input [2:0] s, input [7:0] d);
    begin
      link_up <= l;
      cyclic_run <= l;
      cpu_state <= s;
      cmd_q <= d;
    end
  endtask
endmodule // net_master

// ---- tb.sv ----
// self-checking bench for the hold/clear policy
`timescale 1ns/1ps
`include "hold_clear_map.vh"
`define CHK(a, b) begin n_checks = n_checks + 1; if ((a) !== (b)) begin \
  failures = failures + 1; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg internal_fault = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, q;
  reg [7:0] raw_inputs = 8'h5A;
  wire [31:0] prdata;
  wire pready, pslverr, link_up, cyclic_run, out_data_valid, out_data_held;
  wire [2:0] cpu_state;
  wire [7:0] cyclic_output_bits, out_level, cyclic_input_bits;
  wire [7:0] fw_out_level;
  wire fw_held;
  integer failures = 0, n_checks = 0, k;
  hold_clear_policy hold_clear_policy_i (.*);
  // second copy on the early revision, which must always act as hold
  hold_clear_policy #(.FW_REV(`FW_HOLD_ONLY)) hold_clear_policy_fw_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(),
    .pready(),
    .pslverr(),
    .link_up(link_up),
    .cyclic_run(cyclic_run),
    .cpu_state(cpu_state),
    .internal_fault(internal_fault),
    .cyclic_output_bits(cyclic_output_bits),
    .raw_inputs(raw_inputs),
    .out_level(fw_out_level),
    .out_data_valid(),
    .out_data_held(fw_held),
    .cyclic_input_bits()
  );
  net_master net_master_i (.*);
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  // ----
  // apb master and step helpers
  // ----
  task test_done;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] ad, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (k = 0; k < 20 && pready !== 1'b1; k = k + 1) @(posedge pclk);
      if (k == 20) begin
        failures = failures + 1;
        test_done;
      end
      q = prdata;
      `CHK(pslverr, 1'b0)
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task step(input [1:0] c, input l, input [2:0] s, input [7:0] d,
    input [7:0] eo, input ev);
    begin
      apb(1'b1, `REG_CTRL, {30'h0, c});
      net_master_i.set(l, s, d);
      repeat (3) @(posedge pclk);
      `CHK(out_level, eo)
      `CHK(out_data_valid, ev)
      `CHK(out_data_held, c[0] && (!l || s == `CPU_RESET))
    end
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(q, `CTRL_RESET)
    apb(1'b0, `REG_CNT_LAST, 32'h0);
    `CHK(q, 32'h0)
    step(2'h0,1'b1,`CPU_RUN,8'hA5,8'hA5,1'b1);
    step(2'h0,1'b1,`CPU_STOP,8'hA5,8'h00,1'b0);
    step(2'h0,1'b0,`CPU_RUN,8'hA5,8'h00,1'b0);
    `CHK(fw_out_level, 8'hA5)
    `CHK(fw_held, 1'b1)
    step(2'h1,1'b1,`CPU_RUN,8'h3C,8'h3C,1'b1);
    step(2'h1,1'b0,`CPU_RUN,8'hC3,8'h3C,1'b1);
    step(2'h1,1'b1,`CPU_RESET,8'hC3,8'h3C,1'b1);
    step(2'h1,1'b1,`CPU_STOP,8'h5A,8'h5A,1'b1);
    step(2'h2,1'b1,`CPU_RUN,8'hFF,8'hFF,1'b1);
    step(2'h2,1'b0,`CPU_RUN,8'hFF,8'h00,1'b0);
    step(2'h3,1'b1,`CPU_PAUSE,8'h0F,8'h0F,1'b1);
    step(2'h3,1'b1,`CPU_RESET,8'hF0,8'h0F,1'b0);
    step(2'h2,1'b1,`CPU_ERR,8'h81,8'h81,1'b1);
    net_master_i.stop_off <= 1'b1;
    step(2'h2,1'b1,`CPU_STOP,8'h81,8'h00,1'b1);
    step(2'h0,1'b1,3'h5,8'hFF,8'h00,1'b0);
    step(2'h0,1'b1,`CPU_RUN,8'h00,8'h00,1'b1);
    apb(1'b1, `REG_CNT_BASE, 32'h0000_FFFE);
    step(2'h0,1'b1,`CPU_RUN,8'h01,8'h01,1'b1);
    step(2'h0,1'b1,`CPU_RUN,8'h00,8'h00,1'b1);
    step(2'h0,1'b1,`CPU_RUN,8'h01,8'h01,1'b1);
    apb(1'b0, `REG_CNT_BASE, 32'h0);
    `CHK(q, 32'h0000_FFFF)
    `CHK(cyclic_input_bits, 8'h5A)
    internal_fault <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(out_level, 8'h00)
    `CHK(cyclic_input_bits, 8'h00)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK(q, (32'h1 << `ST_FORCED_OFF_BIT))
    test_done;
  end
endmodule // tb
